//--- stop_wait_mode_entry_control_tb.sv
/*
  Self-checking testbench of the stop and wait mode entry controller.
  Assumes swc_pkg and swc_ctrl are compiled first; the bench drives every input itself.
*/
`timescale 1ns/1ps

module stop_wait_mode_entry_control_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  swc_pkg::swc_irq_s irq_i = '0;
  logic [2:0] ipl_i = 3'h0;
  logic irq_enable_flag_i = 1'b0;
  logic wait_instr_i = 1'b0;
  logic nmi_pin_n_i = 1'b1;
  swc_pkg::swc_clk_s clk_en_o;
  logic stop_mode_o;
  logic wait_mode_o;
  logic wake_o;
  logic wake_nmi_o;
  logic [5:0] wake_vector_o;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic err;
  logic got;

  always #20 clk_sys_i = ~clk_sys_i;

  swc_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_i(irq_i), .ipl_i(ipl_i), .irq_enable_flag_i(irq_enable_flag_i),
    .wait_instr_i(wait_instr_i), .nmi_pin_n_i(nmi_pin_n_i), .clk_en_o(clk_en_o), .stop_mode_o(stop_mode_o),
    .wait_mode_o(wait_mode_o), .wake_o(wake_o), .wake_nmi_o(wake_nmi_o), .wake_vector_o(wake_vector_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= data;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1)
    begin
      check(1'b0, 1'b1, "apb timeout");
      final_report();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_wake(input int limit);
    got = 1'b0;
    for (int i = 0; i < limit && !got; i++)
    begin
      @(posedge clk_sys_i);
      if (wake_o === 1'b1)
        got = 1'b1;
    end
  endtask

  // Entry accepted at the current edge: two drain cycles, then the mode
  task automatic drain_check(input logic is_stop);
    for (int i = 1; i <= 3; i++)
    begin
      @(posedge clk_sys_i);
      check(clk_en_o.cpu_clk_en, i < 3, "cpu clock enable");
      check(clk_en_o.periph_clk_en, i < 3 || !is_stop, "peripheral clock enable");
      check({stop_mode_o, wait_mode_o}, i < 3 ? 2'b00 : {is_stop, !is_stop}, "mode");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check(clk_en_o, 2'b11, "reset clocks");
    for (int a = 0; a < 4; a++)
    begin
      apb(1'b0, 8'(a * 4), 32'h0000_0000);
      check({err, rd}, 33'h0_0000_0000, "reset read");
    end
    apb(1'b1, 8'h10, 32'h0000_0001);
    check(err, 1'b1, "unmapped write error");
    apb(1'b0, 8'h10, 32'h0000_0000);
    check({err, rd}, 33'h1_0000_0000, "unmapped read");
    $display("test_reset done");
  endtask

  task automatic test_protect();
    apb(1'b1, swc_pkg::ADDR_CLK_CTRL_TWO, 32'h0000_0001);
    wait_wake(5);
    check(stop_mode_o, 1'b0, "protected stop write");
    apb(1'b0, swc_pkg::ADDR_CLK_CTRL_TWO, 32'h0000_0000);
    check(rd, 32'h0000_0000, "protected stop bit");
    $display("test_protect done");
  endtask

  task automatic test_stop();
    apb(1'b1, swc_pkg::ADDR_WAKE_LEVEL, 32'h0000_0007);
    ipl_i <= 3'h4;
    apb(1'b1, swc_pkg::ADDR_WAKE_LEVEL, 32'h0000_0004);
    irq_enable_flag_i <= 1'b1;
    apb(1'b1, swc_pkg::ADDR_PROTECT, 32'h0000_0001);
    apb(1'b1, swc_pkg::ADDR_CLK_CTRL_TWO, 32'h0000_0001);
    drain_check(1'b1);
    apb(1'b0, swc_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0001, "stop status");
    irq_i <= '{req: 1'b1, level: 3'h3, vector: 6'h15};
    wait_wake(6);
    check(got, 1'b0, "level below wake field");
    irq_i.level <= 3'h4;
    wait_wake(6);
    check(got, 1'b0, "level equal to wake field and ipl");
    irq_enable_flag_i <= 1'b0;
    irq_i.level <= 3'h5;
    wait_wake(6);
    check(got, 1'b0, "interrupts disabled");
    irq_enable_flag_i <= 1'b1;
    wait_wake(10);
    check(got, 1'b1, "qualifying wake");
    check({wake_nmi_o, wake_vector_o, clk_en_o, stop_mode_o}, {1'b0, 6'h15, 2'b11, 1'b0}, "wake state");
    irq_i <= '0;
    apb(1'b0, swc_pkg::ADDR_CLK_CTRL_TWO, 32'h0000_0000);
    check(rd, 32'h0000_0000, "stop bit cleared");
    apb(1'b1, swc_pkg::ADDR_WAKE_LEVEL, 32'h0000_0007);
    $display("test_stop done");
  endtask

  task automatic test_wait_nmi();
    @(posedge clk_sys_i);
    wait_instr_i <= 1'b1;
    @(posedge clk_sys_i);
    wait_instr_i <= 1'b0;
    drain_check(1'b0);
    irq_i <= '{req: 1'b1, level: 3'h7, vector: 6'h2a};
    wait_wake(6);
    check(got, 1'b0, "level not above seven");
    irq_i <= '0;
    nmi_pin_n_i <= 1'b0;
    wait_wake(10);
    check(got, 1'b1, "nmi wake");
    check({wake_nmi_o, wake_vector_o, clk_en_o, wait_mode_o}, {1'b1, swc_pkg::NMI_VECTOR, 2'b11, 1'b0}, "nmi");
    nmi_pin_n_i <= 1'b1;
    apb(1'b0, swc_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0004, "nmi status");
    $display("test_wait_nmi done");
  endtask

  task automatic test_restop();
    apb(1'b1, swc_pkg::ADDR_CLK_CTRL_TWO, 32'h0000_0001);
    drain_check(1'b1);
    nmi_pin_n_i <= 1'b0;
    wait_wake(10);
    check({got, wake_nmi_o, stop_mode_o, clk_en_o}, 5'b11011, "nmi stop wake");
    nmi_pin_n_i <= 1'b1;
    irq_i <= '{req: 1'b1, level: 3'h7, vector: 6'h3e};
    @(posedge clk_sys_i);
    irq_i <= '0;
    apb(1'b1, swc_pkg::ADDR_CLK_CTRL_TWO, 32'h0000_0001);
    drain_check(1'b1);
    nmi_pin_n_i <= 1'b0;
    wait_wake(10);
    check({got, wake_nmi_o, stop_mode_o, clk_en_o}, 5'b11011, "second nmi stop wake");
    nmi_pin_n_i <= 1'b1;
    apb(1'b1, swc_pkg::ADDR_WAKE_LEVEL, 32'h0000_0004);
    irq_i <= '{req: 1'b1, level: 3'h5, vector: 6'h0b};
    wait_instr_i <= 1'b1;
    @(posedge clk_sys_i);
    wait_instr_i <= 1'b0;
    wait_wake(4);
    check({got, wake_vector_o, wait_mode_o, clk_en_o}, {1'b1, 6'h0b, 1'b0, 2'b11}, "wake in drain");
    irq_i <= '0;
    apb(1'b1, swc_pkg::ADDR_WAKE_LEVEL, 32'h0000_0007);
    $display("test_restop done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    test_reset();
    test_protect();
    test_stop();
    test_wait_nmi();
    test_restop();
    final_report();
  end
endmodule

//--- swc_ctrl.sv
/*
  Stop and wait mode entry controller: APB registers for the clock write
  unprotect bit, the all clocks stop bit and the minimum wake priority field,
  the low power mode sequencer and the clock enables it drives.
  Assumes the highest pending interrupt, the processor priority level and the
  global interrupt enable flag arrive from logic on the same clock, and that
  the NMI pin is asynchronous and active low. This block itself never stops.
*/
// Behaviour
// - Writing 1 to the all clocks stop bit halts the CPU and peripheral clocks and enters stop mode.
// - A write to the all clocks stop bit takes effect only while the unprotect bit is 1.
// - A three-bit minimum wake level is held, and only the NMI or interrupts above it end stop or wait mode.
// - Prefetched instructions may still run for a short drain time before the clocks actually stop.
`timescale 1ns/1ps

module swc_ctrl
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // CPU side
  input wire swc_pkg::swc_irq_s irq_i,
  input wire logic [2:0] ipl_i,
  input wire logic irq_enable_flag_i,
  input wire logic wait_instr_i,
  input wire logic nmi_pin_n_i,
  // Clock control and wake report
  output swc_pkg::swc_clk_s clk_en_o,
  output logic stop_mode_o,
  output logic wait_mode_o,
  output logic wake_o,
  output logic wake_nmi_o,
  output logic [5:0] wake_vector_o
);

  ////////////////////////////////////////////////////////////////////////////
  // NMI pin synchroniser and falling edge
  logic nmi_sync1_reg;
  logic nmi_sync2_reg;
  logic nmi_prev_reg;
  logic nmi_event;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      nmi_sync1_reg <= 1'b1;
      nmi_sync2_reg <= 1'b1;
      nmi_prev_reg <= 1'b1;
    end
    else
    begin
      nmi_sync1_reg <= nmi_pin_n_i;
      nmi_sync2_reg <= nmi_sync1_reg;
      nmi_prev_reg <= nmi_sync2_reg;
    end
  end

  assign nmi_event = nmi_prev_reg & ~nmi_sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // State
  swc_pkg::swc_state_e state_reg;
  swc_pkg::swc_state_e state_next;
  logic [1:0] drain_cnt_reg;
  logic [1:0] drain_cnt_next;
  logic unprotect_reg;
  logic unprotect_next;
  logic stop_bit_reg;
  logic stop_bit_next;
  logic [2:0] wake_level_reg;
  logic [2:0] wake_level_next;
  logic nmi_woke_reg;
  logic nmi_woke_next;
  logic [31:0] prdata_next;
  logic pslverr_next;
  swc_pkg::swc_clk_s clk_en_next;
  logic wake_next;
  logic [5:0] wake_vector_next;

  logic setup_phase;
  logic wr_access;
  logic wr_ctl;
  logic stop_acc;
  logic irq_qual;
  logic wake_any;
  logic in_low_power;
  logic addr_ok;

  assign pready_o = 1'b1;
  assign setup_phase = psel_i & ~penable_i;
  assign wr_access = psel_i & penable_i & pwrite_i;
  assign wr_ctl = wr_access && (paddr_i == swc_pkg::ADDR_CLK_CTRL_TWO);
  // Stop request only counts while unprotected and running
  assign stop_acc = wr_ctl && unprotect_reg && pwdata_i[swc_pkg::STOP_BIT_POS] &&
                    (state_reg == swc_pkg::SWC_RUN);
  // Wake needs a level above both the wake field and the processor level
  assign irq_qual = irq_i.req && irq_enable_flag_i && (irq_i.level > wake_level_reg) &&
                    (irq_i.level > ipl_i);
  assign wake_any = irq_qual | nmi_event;
  assign in_low_power = (state_reg != swc_pkg::SWC_RUN);
  assign addr_ok = (paddr_i == swc_pkg::ADDR_PROTECT) || (paddr_i == swc_pkg::ADDR_CLK_CTRL_TWO) ||
                   (paddr_i == swc_pkg::ADDR_WAKE_LEVEL) || (paddr_i == swc_pkg::ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_next = state_reg;
    drain_cnt_next = drain_cnt_reg;
    unprotect_next = unprotect_reg;
    stop_bit_next = stop_bit_reg;
    wake_level_next = wake_level_reg;
    nmi_woke_next = nmi_woke_reg;
    prdata_next = prdata_o;
    pslverr_next = pslverr_o;
    wake_next = 1'b0;
    wake_vector_next = wake_vector_o;

    // Register writes
    if (wr_access && (paddr_i == swc_pkg::ADDR_PROTECT))
    begin
      unprotect_next = pwdata_i[swc_pkg::UNPROTECT_POS];
    end
    if (wr_ctl && unprotect_reg && (state_reg == swc_pkg::SWC_RUN))
    begin
      stop_bit_next = pwdata_i[swc_pkg::STOP_BIT_POS];
    end
    if (wr_access && (paddr_i == swc_pkg::ADDR_WAKE_LEVEL))
    begin
      wake_level_next = pwdata_i[swc_pkg::WAKE_LSB +: swc_pkg::WAKE_W];
    end

    // Read data and error prepared in the setup phase
    if (setup_phase)
    begin
      prdata_next = swc_pkg::RDATA_ZERO;
      pslverr_next = ~addr_ok;
      if (!pwrite_i)
      begin
        case (paddr_i)
          swc_pkg::ADDR_PROTECT: prdata_next[swc_pkg::UNPROTECT_POS] = unprotect_reg;
          swc_pkg::ADDR_CLK_CTRL_TWO: prdata_next[swc_pkg::STOP_BIT_POS] = stop_bit_reg;
          swc_pkg::ADDR_WAKE_LEVEL: prdata_next[swc_pkg::WAKE_LSB +: swc_pkg::WAKE_W] = wake_level_reg;
          swc_pkg::ADDR_STATUS:
          begin
            prdata_next[swc_pkg::ST_STOP_POS] = stop_mode_o;
            prdata_next[swc_pkg::ST_WAIT_POS] = wait_mode_o;
            prdata_next[swc_pkg::ST_NMI_POS] = nmi_woke_reg;
          end
          default: prdata_next = swc_pkg::RDATA_ZERO;
        endcase
      end
    end

    // Mode sequencer
    case (state_reg)
      swc_pkg::SWC_RUN:
      begin
        drain_cnt_next = 2'h0;
        if (stop_acc)
        begin
          state_next = swc_pkg::SWC_STOP_PEND;
        end
        else if (wait_instr_i)
        begin
          state_next = swc_pkg::SWC_WAIT_PEND;
        end
      end
      swc_pkg::SWC_STOP_PEND, swc_pkg::SWC_WAIT_PEND:
      begin
        // Prefetched instructions keep running until the drain ends
        if (!wake_any)
        begin
          drain_cnt_next = 2'(drain_cnt_reg + 2'h1);
          if (drain_cnt_reg == swc_pkg::DRAIN_LAST)
          begin
            state_next = (state_reg == swc_pkg::SWC_STOP_PEND) ? swc_pkg::SWC_STOP : swc_pkg::SWC_WAIT;
          end
        end
      end
      swc_pkg::SWC_STOP, swc_pkg::SWC_WAIT:
      begin
        drain_cnt_next = 2'h0;
      end
      default:
      begin
        state_next = swc_pkg::SWC_RUN;
        drain_cnt_next = 2'h0;
      end
    endcase

    // Wake from any low power state or drain
    if (in_low_power && wake_any)
    begin
      state_next = swc_pkg::SWC_RUN;
      drain_cnt_next = 2'h0;
      stop_bit_next = 1'b0;
      wake_next = 1'b1;
      wake_vector_next = nmi_event ? swc_pkg::NMI_VECTOR : irq_i.vector;
      nmi_woke_next = nmi_event;
    end

    // Clock enables follow the next state
    clk_en_next.cpu_clk_en = (state_next != swc_pkg::SWC_STOP) && (state_next != swc_pkg::SWC_WAIT);
    clk_en_next.periph_clk_en = (state_next != swc_pkg::SWC_STOP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_reg <= swc_pkg::SWC_RUN;
      drain_cnt_reg <= 2'h0;
      unprotect_reg <= swc_pkg::UNPROTECT_RST;
      stop_bit_reg <= swc_pkg::STOP_BIT_RST;
      wake_level_reg <= swc_pkg::WAKE_LEVEL_RST;
      nmi_woke_reg <= 1'b0;
      prdata_o <= swc_pkg::RDATA_ZERO;
      pslverr_o <= 1'b0;
      clk_en_o <= 2'h3;
      stop_mode_o <= 1'b0;
      wait_mode_o <= 1'b0;
      wake_o <= 1'b0;
      wake_nmi_o <= 1'b0;
      wake_vector_o <= 6'h00;
    end
    else
    begin
      state_reg <= state_next;
      drain_cnt_reg <= drain_cnt_next;
      unprotect_reg <= unprotect_next;
      stop_bit_reg <= stop_bit_next;
      wake_level_reg <= wake_level_next;
      nmi_woke_reg <= nmi_woke_next;
      prdata_o <= prdata_next;
      pslverr_o <= pslverr_next;
      clk_en_o <= clk_en_next;
      stop_mode_o <= (state_next == swc_pkg::SWC_STOP);
      wait_mode_o <= (state_next == swc_pkg::SWC_WAIT);
      wake_o <= wake_next;
      wake_nmi_o <= wake_next & nmi_event;
      wake_vector_o <= wake_vector_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_stop_halts_clocks: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    stop_mode_o |-> (!clk_en_o.cpu_clk_en && !clk_en_o.periph_clk_en))
    else $error("clocks running in stop mode");

  chk_stop_entry_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    stop_acc |=> clk_en_o.cpu_clk_en [*2] ##1 (stop_mode_o || wake_o || $past(wake_o)))
    else $error("stop entry not after the prefetch drain");

  chk_protect_blocks: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_ctl && !unprotect_reg) |=> ($stable(stop_bit_reg) && !stop_mode_o && !$rose(drain_cnt_reg[0])))
    else $error("protected stop bit changed");

  chk_wake_above_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wake_o && !wake_nmi_o) |-> (($past(irq_i.level) > $past(wake_level_reg)) &&
                                 ($past(irq_i.level) > $past(ipl_i))))
    else $error("wake by an interrupt at or below the wake level");

  chk_low_irq_stays: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (stop_mode_o && !nmi_event && (irq_i.level <= wake_level_reg)) |=> stop_mode_o)
    else $error("stop mode left by a non-qualifying interrupt");

  chk_wake_restarts: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ($past(stop_mode_o) && wake_o) |-> (clk_en_o.cpu_clk_en && clk_en_o.periph_clk_en &&
                                       !stop_mode_o && !stop_bit_reg &&
                                       (wake_nmi_o || (wake_vector_o == $past(irq_i.vector)))))
    else $error("wake did not restart clocks or vector");

  chk_wake_any_state: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (in_low_power && wake_any) |=> (wake_o && clk_en_o.cpu_clk_en && clk_en_o.periph_clk_en &&
                                     !stop_mode_o && !wait_mode_o))
    else $error("wake did not return to run");

  chk_wake_one_cycle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");

  chk_stop_unprotected: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(stop_mode_o) |-> $past(unprotect_reg, 3))
    else $error("stop mode entered without unprotect");

endmodule

//--- swc_pkg.sv
/*
  Shared constants and types of the stop and wait mode entry controller:
  register offsets, field positions, reset values, drain timing, mode states.
  Assumes a 25 MHz system clock and a 32-bit APB register bus.
*/
package swc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_PROTECT = 8'h00;
  localparam logic [7:0] ADDR_CLK_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_WAKE_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and widths
  localparam int UNPROTECT_POS = 0;
  localparam int STOP_BIT_POS = 0;
  localparam int WAKE_LSB = 0;
  localparam int WAKE_W = 3;
  localparam int ST_STOP_POS = 0;
  localparam int ST_WAIT_POS = 1;
  localparam int ST_NMI_POS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic UNPROTECT_RST = 1'b0;
  localparam logic STOP_BIT_RST = 1'b0;
  localparam logic [2:0] WAKE_LEVEL_RST = 3'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // Vector reported for a wake by the non-maskable interrupt; value is arbitrary
  localparam logic [5:0] NMI_VECTOR = 6'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PREFETCH_DRAIN_NS = 80;
  localparam int PREFETCH_DRAIN_CYC = (PREFETCH_DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] DRAIN_LAST = 2'(PREFETCH_DRAIN_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    SWC_RUN,
    SWC_STOP_PEND,
    SWC_STOP,
    SWC_WAIT_PEND,
    SWC_WAIT
  } swc_state_e;

  typedef struct packed {
    logic req;
    logic [2:0] level;
    logic [5:0] vector;
  } swc_irq_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
  } swc_clk_s;

endpackage
